// >>> hw/stack_irq_pkg.sv
// Package with constants and types for the stack and interrupt control block.
package stack_irq_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_STACK_POINTER_LOW_BYTE = 6'h3d;
    localparam logic [5:0] ADDR_STACK_POINTER_HIGH_BYTE = 6'h3e;
    localparam logic [5:0] ADDR_STATUS_FLAGS_REG = 6'h3f;
    localparam logic [7:0] RST_STACK_POINTER_LOW_BYTE = 8'hff;
    localparam logic [7:0] RST_STACK_POINTER_HIGH_BYTE = 8'h20;
    localparam int GIE_BIT = 7;
    // ------------------------------------------------------------
    // Sources and vectors
    // ------------------------------------------------------------
    localparam int NUM_SRC = 8;
    localparam int SRC_W = 3;
    localparam logic [15:0] VECTOR_STEP = 16'h0002;
    localparam logic [15:0] BOOT_START = 16'h3800;
    localparam logic [15:0] RESET_VECTOR_APP = 16'h0000;
    // ------------------------------------------------------------
    // Timing counts, in core clock cycles, and stack pointer steps
    // ------------------------------------------------------------
    localparam logic [3:0] ENTRY_CYCLES = 4'h5;
    localparam logic [3:0] WAKE_EXTRA_CYCLES = 4'h5;
    localparam logic [3:0] EXIT_CYCLES = 4'h5;
    localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
    localparam logic [15:0] SP_STEP_CALL = 16'h0002;
    localparam logic [15:0] SP_STEP_INTERRUPT_EXIT = 16'h0003;
    // ------------------------------------------------------------
    // Stack operations requested by the sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_RET
    } stack_op_t;
endpackage

// >>> hw/irq_arb_if.sv
// Interface between the controller and its priority arbiter.
`timescale 1ns/100ps
`default_nettype none
interface irq_arb_if;
    logic [stack_irq_pkg::NUM_SRC-1:0] req;
    logic any;
    logic [stack_irq_pkg::SRC_W-1:0] idx;
    modport ctrl (output req, input any, input idx);
    modport arb (input req, output any, output idx);
endinterface
`default_nettype wire

// >>> hw/irq_priority_arb.sv
// Fixed priority arbiter: lowest source index wins.
`timescale 1ns/100ps
`default_nettype none
module irq_priority_arb (
    // Request side
    irq_arb_if.arb arb
);
    // Scan from the highest index down so the lowest index wins last.
    always_comb begin
        arb.any = 1'b0;
        arb.idx = '0;
        for (int i = stack_irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (arb.req[i]) begin
                arb.any = 1'b1;
                arb.idx = stack_irq_pkg::SRC_W'(i);
            end
        end
    end
endmodule // irq_priority_arb
`default_nettype wire

// >>> hw/stack_irq_ctrl.sv
// Stack pointer and interrupt entry and exit control for an 8-bit core.
// Function
// - Stack grows downward, pointer marks top.
// - Byte push decrements, pop increments by one.
// - Calls and entry subtract two; returns add two.
// - Pointer bytes at I/O 0x3E and 0x3D.
// - Reset loads last internal SRAM address.
// - Core runs on undivided core clock.
// - Register ALU operation completes in one cycle.
// - Distinct vectors; lower address wins priority.
// - Take interrupt only with both enables set.
// - Relocate bit and fuse move vectors.
// - Entry clears global enable until set again.
// - Flags clear on vectoring or written one.
// - Flag conditions stay latched while disabled.
// - Level sources request only while present.
// - One instruction runs after interrupt exit.
// - Status flags never saved or restored.
// - Global disable blocks interrupts at once.
// - Instruction after global enable runs first.
// - Entry takes five cycles, after instruction.
// - Wake from sleep adds five cycles.
// - Exit five cycles, pointer plus three, enable.
`timescale 1ns/100ps
`default_nettype none
module stack_irq_ctrl (
    // Clock and reset
    // core clock
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // I/O register port
    input wire logic [5:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // Stack operations from the sequencer
    input wire stack_irq_pkg::stack_op_t stack_op_i,
    input wire logic interrupt_exit_i,
    input wire logic sei_i,
    input wire logic cli_i,
    input wire logic instr_boundary_i,
    input wire logic sleeping_i,
    // Interrupt sources
    input wire logic [stack_irq_pkg::NUM_SRC-1:0] src_event_i,
    input wire logic [stack_irq_pkg::NUM_SRC-1:0] src_is_level_i,
    input wire logic [stack_irq_pkg::NUM_SRC-1:0] src_enable_i,
    input wire logic [stack_irq_pkg::NUM_SRC-1:0] flag_clear_i,
    // Vector control
    input wire logic vector_table_relocate_i,
    input wire logic boot_reset_vector_fuse_i,
    // Status and sequencer controls
    output logic [stack_irq_pkg::NUM_SRC-1:0] flag_o,
    output logic [15:0] stack_pointer_o,
    output logic global_enable_o,
    output logic irq_busy_o,
    output logic irq_taken_o,
    output logic [15:0] irq_vector_o,
    output logic [15:0] reset_vector_o
);
    // ------------------------------------------------------------
    // Local state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_RUN, ST_WAKE, ST_ENTRY, ST_EXIT} seq_state_t;
    seq_state_t state_r, state_nxt;
    logic [15:0] sp_r, sp_nxt;
    logic [7:0] status_flags_reg_r, status_flags_reg_nxt;
    logic [stack_irq_pkg::NUM_SRC-1:0] flag_r, flag_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic hold_r, hold_nxt;
    logic [stack_irq_pkg::SRC_W-1:0] win_r, win_nxt;
    logic [15:0] vec_r, vec_nxt;
    logic taken_r, taken_nxt;
    logic [stack_irq_pkg::NUM_SRC-1:0] req;
    logic grant;
    typedef enum logic [1:0] {SEL_NONE, SEL_SP_LOW, SEL_SP_HIGH, SEL_STATUS} io_sel_t;
    io_sel_t io_sel;
    irq_arb_if arb_bus ();

    // ------------------------------------------------------------
    // Behaviour notes
    // ------------------------------------------------------------
    // The sequencer reports what it executes through one-cycle strobes:
    // a stack operation code, the exit, enable and disable instructions,
    // and a boundary strobe in the cycle where an instruction completes.
    // This block never fetches or decodes instructions itself.
    //
    // Interrupts are only granted on a boundary strobe, so a multi-cycle
    // instruction always finishes before its entry sequence starts.
    // The grant edge clears the global enable and the winner's flag, and
    // loads the vector register; the entry then runs for its fixed count
    // and lowers the pointer by two in its last cycle, which matches the
    // push of the return address by the sequencer.
    //
    // A request that meets the grant edge together with the disable strobe
    // is refused outright. Checking the strobe directly, rather than the
    // registered enable bit, is what makes the disable take effect at once.
    //
    // The enable strobe and the end of an exit both arm a one-instruction
    // hold. The hold is released by the next boundary strobe that is not
    // itself an enable or an exit, so exactly one instruction of the
    // interrupted program runs before a pending request is served.
    //
    // While the core sleeps, a grant first passes through the wake state,
    // which adds its own fixed count ahead of the normal entry. The start-up
    // time of the sleep mode itself is counted outside this block.
    //
    // The pointer is a plain 16-bit register. Nothing guards against it
    // wrapping below the start of data memory; keeping it in range is left
    // to software, as is saving the status register around a handler.
    //
    // Flags latch on a pulse from a flag-type source and stay latched while
    // either enable is clear. A software clear and a new event in the same
    // cycle leave the flag set, so an event is never lost to a late clear.
    // Level-type sources bypass the flags entirely and request service only
    // while their condition is present.
    //
    // Vectors are computed from the winner's index: reset owns the first
    // slot and source n the (n+1)th slot after it, at the application base or at
    // the start of the boot section when relocation is selected.
    //
    // Register writes from the I/O port are applied after the stack
    // operation in the same cycle, so a software write to a pointer byte
    // wins for that byte over a concurrent push or pop.
    //
    // Read data is combinational on the address and strobe; the sequencer
    // samples it in the same cycle and the value is zero otherwise.

    // ------------------------------------------------------------
    // I/O address decode
    // ------------------------------------------------------------
    // The write and read paths share one decode so they cannot drift.
    // An address outside the three mapped registers selects nothing.
    function automatic io_sel_t io_select(input logic [5:0] addr);
        unique case (addr)
            stack_irq_pkg::ADDR_STACK_POINTER_LOW_BYTE: io_select = SEL_SP_LOW;
            stack_irq_pkg::ADDR_STACK_POINTER_HIGH_BYTE: io_select = SEL_SP_HIGH;
            stack_irq_pkg::ADDR_STATUS_FLAGS_REG: io_select = SEL_STATUS;
            default: io_select = SEL_NONE;
        endcase
    endfunction

    assign io_sel = io_select(io_addr_i);

    // ------------------------------------------------------------
    // Vector address computation
    // ------------------------------------------------------------
    // The vector of source n sits n+1 steps above reset; reset is vector zero.
    function automatic logic [15:0] vector_of(input logic [stack_irq_pkg::SRC_W-1:0] idx, input logic reloc);
        logic [15:0] base;
        base = reloc ? stack_irq_pkg::BOOT_START : stack_irq_pkg::RESET_VECTOR_APP;
        vector_of = base + 16'((idx + 16'h0001) * stack_irq_pkg::VECTOR_STEP);
    endfunction

    // ------------------------------------------------------------
    // Request gating and arbitration
    // ------------------------------------------------------------
    // level sources pass live; flag sources pass latched.
    generate
        for (genvar g = 0; g < stack_irq_pkg::NUM_SRC; g++) begin : g_req
            assign req[g] = src_enable_i[g] & (src_is_level_i[g] ? src_event_i[g] : flag_r[g]);
        end
    endgenerate
    assign arb_bus.req = req;

    irq_priority_arb u_arb (
        .arb(arb_bus.arb)
    );

    // Gate the grant on the global enable, a completed instruction and no hold.
    // same-cycle disable
    always_comb begin
        grant = arb_bus.any & status_flags_reg_r[stack_irq_pkg::GIE_BIT] & ~cli_i & ~sei_i & ~hold_r
              & instr_boundary_i & (state_r == ST_RUN);
    end

    // ------------------------------------------------------------
    // Next state for flags, status, sequencer and pointer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        sp_nxt = sp_r;
        status_flags_reg_nxt = status_flags_reg_r;
        cnt_nxt = cnt_r;
        hold_nxt = hold_r;
        win_nxt = win_r;
        vec_nxt = vec_r;
        taken_nxt = 1'b0;
        // latch flags; written one clears, set wins over clear.
        flag_nxt = (flag_r & ~flag_clear_i) | (src_event_i & ~src_is_level_i);

        // A completed instruction releases the one-instruction hold.
        if (instr_boundary_i && state_r == ST_RUN && !sei_i && !interrupt_exit_i) begin
            hold_nxt = 1'b0;
        end

        unique case (stack_op_i)
            stack_irq_pkg::OP_PUSH: sp_nxt = sp_r - stack_irq_pkg::SP_STEP_BYTE;
            stack_irq_pkg::OP_POP: sp_nxt = sp_r + stack_irq_pkg::SP_STEP_BYTE;
            stack_irq_pkg::OP_CALL: sp_nxt = sp_r - stack_irq_pkg::SP_STEP_CALL;
            stack_irq_pkg::OP_RET: sp_nxt = sp_r + stack_irq_pkg::SP_STEP_CALL;
            default: sp_nxt = sp_r;
        endcase

        // Instruction controls of the global enable.
        // immediate disable
        if (cli_i) begin
            status_flags_reg_nxt[stack_irq_pkg::GIE_BIT] = 1'b0;
        end
        if (sei_i) begin
            status_flags_reg_nxt[stack_irq_pkg::GIE_BIT] = 1'b1;
            hold_nxt = 1'b1;
        end

        if (io_wr_i) begin
            unique case (io_sel)
                SEL_SP_LOW: sp_nxt[7:0] = io_wdata_i;
                SEL_SP_HIGH: sp_nxt[15:8] = io_wdata_i;
                SEL_STATUS: status_flags_reg_nxt = io_wdata_i;
                SEL_NONE: ;
            endcase
        end

        unique case (state_r)
            ST_RUN: begin
                if (grant) begin
                    win_nxt = arb_bus.idx;
                    vec_nxt = vector_of(arb_bus.idx, vector_table_relocate_i);
                    flag_nxt[arb_bus.idx] = src_event_i[arb_bus.idx] & ~src_is_level_i[arb_bus.idx];
                    status_flags_reg_nxt[stack_irq_pkg::GIE_BIT] = 1'b0;
                    if (sleeping_i) begin
                        state_nxt = ST_WAKE;
                        cnt_nxt = stack_irq_pkg::WAKE_EXTRA_CYCLES - 4'h1;
                    end else begin
                        state_nxt = ST_ENTRY;
                        cnt_nxt = stack_irq_pkg::ENTRY_CYCLES - 4'h1;
                    end
                end else if (interrupt_exit_i) begin
                    state_nxt = ST_EXIT;
                    cnt_nxt = stack_irq_pkg::EXIT_CYCLES - 4'h1;
                end
            end
            ST_WAKE: begin
                if (cnt_r == 4'h0) begin
                    state_nxt = ST_ENTRY;
                    cnt_nxt = stack_irq_pkg::ENTRY_CYCLES - 4'h1;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_ENTRY: begin
                // five-cycle entry, pointer drops by two on the last cycle.
                if (cnt_r == 4'h0) begin
                    state_nxt = ST_RUN;
                    sp_nxt = sp_r - stack_irq_pkg::SP_STEP_CALL;
                    taken_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_EXIT: begin
                // five cycles, plus three, enable set
                if (cnt_r == 4'h0) begin
                    state_nxt = ST_RUN;
                    sp_nxt = sp_r + stack_irq_pkg::SP_STEP_INTERRUPT_EXIT;
                    status_flags_reg_nxt[stack_irq_pkg::GIE_BIT] = 1'b1;
                    hold_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // every register settles in one cycle.
    // pointer resets to last SRAM address.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= ST_RUN;
            sp_r <= {stack_irq_pkg::RST_STACK_POINTER_HIGH_BYTE, stack_irq_pkg::RST_STACK_POINTER_LOW_BYTE};
            status_flags_reg_r <= 8'h00;
            flag_r <= '0;
            cnt_r <= 4'h0;
            hold_r <= 1'b0;
            win_r <= '0;
            vec_r <= 16'h0000;
            taken_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sp_r <= sp_nxt;
            status_flags_reg_r <= status_flags_reg_nxt;
            flag_r <= flag_nxt;
            cnt_r <= cnt_nxt;
            hold_r <= hold_nxt;
            win_r <= win_nxt;
            vec_r <= vec_nxt;
            taken_r <= taken_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------
    // Read data is combinational on the address; unmapped reads return zero.
    always_comb begin
        io_rdata_o = 8'h00;
        if (io_rd_i) begin
            unique case (io_sel)
                SEL_SP_LOW: io_rdata_o = sp_r[7:0];
                SEL_SP_HIGH: io_rdata_o = sp_r[15:8];
                SEL_STATUS: io_rdata_o = status_flags_reg_r;
                SEL_NONE: io_rdata_o = 8'h00;
            endcase
        end
    end

    assign flag_o = flag_r;
    assign stack_pointer_o = sp_r;
    assign global_enable_o = status_flags_reg_r[stack_irq_pkg::GIE_BIT];
    assign irq_busy_o = (state_r != ST_RUN);
    assign irq_taken_o = taken_r;
    assign irq_vector_o = vec_r;
    assign reset_vector_o = boot_reset_vector_fuse_i ? stack_irq_pkg::BOOT_START : stack_irq_pkg::RESET_VECTOR_APP;
endmodule // stack_irq_ctrl
`default_nettype wire

// >>> sim/irq_src_model.sv
// Model of the peripheral interrupt sources.
`timescale 1ns/100ps
`default_nettype none
module irq_src_model (
    // Commands from the bench
    input wire logic [7:0] fire_i,
    input wire logic [7:0] hold_i,
    // Source conditions
    output logic [7:0] event_o
);
    // pulse and level
    // A flag source fires for one cycle; a level source stays up only while held.
    assign event_o = fire_i | hold_i;
endmodule // irq_src_model
`default_nettype wire

// >>> sim/stack_irq_ctrl_asserts.sv
// Checker for the stack and interrupt control block.
`timescale 1ns/100ps
`default_nettype none
module stack_irq_ctrl_asserts (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Requests
    input wire logic [5:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_wdata_i,
    input wire stack_irq_pkg::stack_op_t stack_op_i,
    input wire logic interrupt_exit_i,
    input wire logic sei_i,
    input wire logic cli_i,
    input wire logic sleeping_i,
    // Outputs watched
    input wire logic [15:0] stack_pointer_o,
    input wire logic global_enable_o,
    input wire logic irq_busy_o,
    input wire logic irq_taken_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Stack steps are only judged when no other pointer update competes.
    logic calm;
    assign calm = !io_wr_i && !irq_busy_o && !irq_taken_o;
    push_step_a: assert property (calm && stack_op_i == stack_irq_pkg::OP_PUSH
        |=> stack_pointer_o == $past(stack_pointer_o) - 16'h0001) else $error("push step wrong");
    call_step_a: assert property (calm && stack_op_i == stack_irq_pkg::OP_CALL
        |=> stack_pointer_o == $past(stack_pointer_o) - 16'h0002) else $error("call step wrong");
    low_write_a: assert property (io_wr_i && io_addr_i == stack_irq_pkg::ADDR_STACK_POINTER_LOW_BYTE
        |=> stack_pointer_o[7:0] == $past(io_wdata_i)) else $error("low byte write lost");
    entry_len_a: assert property ($rose(irq_busy_o) && !$past(interrupt_exit_i) && !$past(sleeping_i)
        |-> irq_busy_o [*5] ##1 irq_taken_o) else $error("entry length wrong");
    entry_sp_a: assert property (irq_taken_o
        |-> stack_pointer_o == $past(stack_pointer_o) - 16'h0002) else $error("entry pointer wrong");
    exit_seq_a: assert property (interrupt_exit_i && !irq_busy_o |=> irq_busy_o [*5] ##1 (!irq_busy_o
        && global_enable_o && stack_pointer_o == $past(stack_pointer_o, 6) + 16'h0003)) else $error("exit wrong");
    ge_clear_a: assert property ($rose(irq_busy_o) && !$past(interrupt_exit_i) |-> !global_enable_o)
        else $error("enable kept on entry");
    ge_gate_a: assert property (!global_enable_o && !interrupt_exit_i |=> !$rose(irq_busy_o))
        else $error("entry while disabled");
    cli_block_a: assert property (cli_i && !interrupt_exit_i && !irq_busy_o |=> !irq_busy_o && !global_enable_o)
        else $error("entry after disable");
    sei_next_a: assert property (sei_i && !interrupt_exit_i && !irq_busy_o |=> !irq_busy_o)
        else $error("entry right after enable");
    cover property (irq_taken_o);
    cover property (interrupt_exit_i);
    cover property (cli_i);
endmodule // stack_irq_ctrl_asserts
bind stack_irq_ctrl stack_irq_ctrl_asserts chk (.ref_clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_wdata_i,
    .stack_op_i, .interrupt_exit_i, .sei_i, .cli_i, .sleeping_i, .stack_pointer_o, .global_enable_o, .irq_busy_o,
    .irq_taken_o);
`default_nettype wire

// >>> sim/test_stack_and_interrupt_control.sv
// Self-checking bench for the stack and interrupt control block.
`timescale 1ns/100ps
`default_nettype none
module test_stack_and_interrupt_control;
    logic clk, rst, wr, rd, interrupt_exit, sei, cli, bnd, slp, reloc, fuse, ge, busy, taken;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, fire, hold, lvl, ena, fclr, ev, flag;
    logic [15:0] sp, vec, rvec;
    stack_irq_pkg::stack_op_t op;
    int n_fail, n_tests;
    stack_irq_ctrl dut (.ref_clk_i(clk), .rst_i(rst), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd),
        .io_wdata_i(wdata), .io_rdata_o(rdata), .stack_op_i(op), .interrupt_exit_i(interrupt_exit), .sei_i(sei), .cli_i(cli),
        .instr_boundary_i(bnd), .sleeping_i(slp), .src_event_i(ev), .src_is_level_i(lvl),
        .src_enable_i(ena), .flag_clear_i(fclr), .vector_table_relocate_i(reloc),
        .boot_reset_vector_fuse_i(fuse), .flag_o(flag), .stack_pointer_o(sp), .global_enable_o(ge),
        .irq_busy_o(busy), .irq_taken_o(taken), .irq_vector_o(vec), .reset_vector_o(rvec));
    irq_src_model src (.fire_i(fire), .hold_i(hold), .event_o(ev));
    // Free-running core clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic final_report();
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data is combinational, so it is sampled inside the strobe cycle.
    task automatic io_read(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        #1;
        chk("rdata", {8'h00, e}, {8'h00, rdata});
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic do_op(input stack_irq_pkg::stack_op_t o, input logic [15:0] e);
        @(posedge clk);
        op <= o;
        @(posedge clk);
        op <= stack_irq_pkg::OP_NONE;
        #1;
        chk("sp", e, sp);
    endtask
    // Pulses {exit, enable, disable} and lets that edge settle.
    task automatic ctl(input logic [2:0] c);
        @(posedge clk);
        {interrupt_exit, sei, cli} <= c;
        @(posedge clk);
        {interrupt_exit, sei, cli} <= 3'h0;
        #1;
    endtask
    task automatic wait_busy();
        int w;
        w = 0;
        while (busy !== 1'b1) begin
            @(posedge clk);
            #1;
            w++;
            if (w > 40) begin
                n_fail++;
                final_report();
            end
        end
    endtask
    task automatic run_busy(input int len);
        int n;
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("busy cycles", 16'(len), 16'(n));
    endtask
    task automatic idle_chk(input int k);
        repeat (k) begin
            @(posedge clk);
            #1;
            chk("busy", 16'h0000, {15'h0000, busy});
        end
    endtask
    // Main sequence; source 7 is never enabled and source 6 is a level source.
    initial begin
        rst = 1'b1;
        {wr, rd, interrupt_exit, sei, cli, slp, reloc, fuse} = '0;
        {addr, wdata, fire, hold, fclr} = '0;
        bnd = 1'b1;
        lvl = 8'h40;
        ena = 8'h7f;
        op = stack_irq_pkg::OP_NONE;
        n_fail = 0;
        n_tests = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("sp", 16'h20ff, sp);
        chk("rvec", 16'h0000, rvec);
        io_read(6'h3d, 8'hff);
        io_read(6'h3e, 8'h20);
        io_read(6'h10, 8'h00);
        @(posedge clk);
        fuse <= 1'b1;
        io_write(6'h3e, 8'h01);
        io_write(6'h3d, 8'h80);
        #1;
        chk("sp", 16'h0180, sp);
        chk("rvec", 16'h3800, rvec);
        do_op(stack_irq_pkg::OP_PUSH, 16'h017f);
        do_op(stack_irq_pkg::OP_POP, 16'h0180);
        do_op(stack_irq_pkg::OP_CALL, 16'h017e);
        do_op(stack_irq_pkg::OP_RET, 16'h0180);
        @(posedge clk);
        fire <= 8'h28;
        @(posedge clk);
        fire <= 8'h00;
        idle_chk(2);
        chk("flag", 16'h0028, {8'h00, flag});
        ctl(3'h2);
        idle_chk(1);
        wait_busy();
        chk("vec", 16'h0008, vec);
        chk("ge", 16'h0000, {15'h0000, ge});
        chk("flag", 16'h0020, {8'h00, flag});
        run_busy(5);
        chk("taken", 16'h0001, {15'h0000, taken});
        chk("sp", 16'h017e, sp);
        @(posedge clk);
        reloc <= 1'b1;
        ctl(3'h4);
        run_busy(5);
        chk("sp", 16'h0181, sp);
        chk("ge", 16'h0001, {15'h0000, ge});
        idle_chk(1);
        wait_busy();
        chk("vec", 16'h380c, vec);
        run_busy(5);
        ctl(3'h4);
        run_busy(5);
        chk("sp", 16'h0182, sp);
        idle_chk(2);
        @(posedge clk);
        fire <= 8'h80;
        @(posedge clk);
        fire <= 8'h00;
        idle_chk(3);
        chk("flag", 16'h0080, {8'h00, flag});
        @(posedge clk);
        cli <= 1'b1;
        fire <= 8'h01;
        @(posedge clk);
        cli <= 1'b0;
        fire <= 8'h00;
        idle_chk(3);
        chk("flag", 16'h0081, {8'h00, flag});
        @(posedge clk);
        fclr <= 8'h01;
        @(posedge clk);
        fclr <= 8'h00;
        #1;
        chk("flag", 16'h0080, {8'h00, flag});
        @(posedge clk);
        hold <= 8'h40;
        repeat (3) @(posedge clk);
        hold <= 8'h00;
        ctl(3'h2);
        idle_chk(4);
        @(posedge clk);
        slp <= 1'b1;
        hold <= 8'h40;
        wait_busy();
        chk("vec", 16'h380e, vec);
        run_busy(10);
        final_report();
    end
endmodule // test_stack_and_interrupt_control
`default_nettype wire
